// ---- rtl/tdtl_regs.vh ----
// register offsets, field positions and reset values for the dead-time block
`ifndef TDTL_REGS_VH
`define TDTL_REGS_VH
`define TDTL_ADDR_W 4
`define TDTL_OFF_BDT 4'h0
`define TDTL_OFF_CTRL2 4'h1
`define TDTL_OFF_CCEN 4'h2
`define TDTL_OFF_CCM 4'h3
`define TDTL_OFF_STAT 4'h4
// brake_dead_time_control fields
`define TDTL_DTS_HI 7
`define TDTL_DTS_LO 0
`define TDTL_LOCK_HI 9
`define TDTL_LOCK_LO 8
`define TDTL_IDLE_OFF_STATE_SELECT 10
`define TDTL_RUN_OFF_STATE_SELECT 11
`define TDTL_BRAKE_INPUT_ENABLE 12
`define TDTL_BRAKE_INPUT_POLARITY 13
`define TDTL_AUTOMATIC_OUTPUT_ENABLE 14
`define TDTL_MAIN_OUTPUT_ENABLE 15
// control two: idle output state bits, channel at bit 0, complement bit 1
`define TDTL_OIS 0
`define TDTL_NOIS 1
// channel enable register: enable, polarity, complementary enable, polarity
`define TDTL_CCEN 0
`define TDTL_CCPOL 1
`define TDTL_CCNEN 2
`define TDTL_CCNPOL 3
// channel mode register: compare mode [2:0], preload enable bit 3
`define TDTL_OCM_HI 2
`define TDTL_OCM_LO 0
`define TDTL_OCPEN 3
// lock levels
`define TDTL_LOCK_OFF 2'h0
`define TDTL_LOCK_L1 2'h1
`define TDTL_LOCK_L2 2'h2
`define TDTL_LOCK_L3 2'h3
// dead-time encodings
`define TDTL_BASE1 9'h000
`define TDTL_BASE64 9'h040
`define TDTL_BASE32 9'h020
`define TDTL_SH1 3'h1
`define TDTL_SH3 3'h3
`define TDTL_SH4 3'h4
`define TDTL_RST16 16'h0000
`define TDTL_RST4 4'h0
`endif

// ---- rtl/tdtl_dead_time_lock.v ----
// brake/dead-time register, write lock and complementary output shaping
//
// Summary of operation
// - Setting top bit 0 gives dead time = full 8-bit value times one base period.
// - Top bits 10 give dead time = (64 + low six bits) times two base periods.
// - Top bits 110 give dead time = (32 + low five bits) times eight periods.
// - Top bits 111 give dead time = (32 + low five bits) times sixteen periods.
// - Lock level zero leaves every lockable bit freely writable.
// - Lock level one freezes dead time, brake enable/polarity, auto enable, idle states.
// - Lock level two also freezes output polarities and the off-state selects.
// - Lock level three also freezes compare mode and compare preload enable.
// - The lock level field takes only the first write after each reset.
// - With main enable low, idle off-state 1 drives inactive then idle level.
// - With main enable high, run off-state 1 drives the inactive level first.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "tdtl_regs.vh"
module tdtl_dead_time_lock #(
    parameter DT_W = 13,
    parameter DTCK_DIV = 1
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // register port
    input wire [`TDTL_ADDR_W-1:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rdata,
    // reference waveform from the compare stage
    input wire oc_ref,
    // channel outputs, two signals each
    output reg channel_output,
    output reg channel_output_oe,
    output reg complementary_output,
    output reg complementary_output_oe,
    // live view of protected settings
    output wire brake_input_enable,
    output wire brake_input_polarity,
    output wire automatic_output_enable,
    output wire [2:0] compare_output_mode,
    output wire compare_preload_enable
);
    reg [15:0] bdt_q;
    reg [1:0] ctrl2_q;
    reg [3:0] ccen_q;
    reg [3:0] ccm_q;
    reg lock_done_q;
    reg [DT_W-1:0] dt_cyc;
    reg [DT_W-1:0] cnt_q;
    reg [DT_W-1:0] dtck_q;
    reg ref_q;
    reg en_q;
    reg dt_busy_q;
    reg startup_q;
    wire [7:0] dead_time_setting;
    wire [1:0] lock;
    wire lk1;
    wire lk2;
    wire lk3;
    wire moe;
    wire ch_en;
    wire pol;
    wire npol;
    wire ch_rise;
    wire ref_chg;
    wire dt_tick;
    wire cnt_done;

    assign dead_time_setting = bdt_q[`TDTL_DTS_HI:`TDTL_DTS_LO];
    assign lock = bdt_q[`TDTL_LOCK_HI:`TDTL_LOCK_LO];
    assign lk1 = (lock != `TDTL_LOCK_OFF);
    assign lk2 = (lock == `TDTL_LOCK_L2) || (lock == `TDTL_LOCK_L3);
    assign lk3 = (lock == `TDTL_LOCK_L3);
    assign moe = bdt_q[`TDTL_MAIN_OUTPUT_ENABLE];
    assign ch_en = ccen_q[`TDTL_CCEN];
    assign pol = ccen_q[`TDTL_CCPOL];
    assign npol = ccen_q[`TDTL_CCNPOL];
    assign brake_input_enable = bdt_q[`TDTL_BRAKE_INPUT_ENABLE];
    assign brake_input_polarity = bdt_q[`TDTL_BRAKE_INPUT_POLARITY];
    assign automatic_output_enable = bdt_q[`TDTL_AUTOMATIC_OUTPUT_ENABLE];
    assign compare_output_mode = ccm_q[`TDTL_OCM_HI:`TDTL_OCM_LO];
    assign compare_preload_enable = ccm_q[`TDTL_OCPEN];

    // dead-time length in base periods from the encoded field
    always @* begin
        dt_cyc = {DT_W{1'b0}};
        if (!dead_time_setting[7]) begin
            dt_cyc = {{(DT_W-8){1'b0}}, dead_time_setting};
        end else if (!dead_time_setting[6]) begin
            dt_cyc = {{(DT_W-9){1'b0}}, `TDTL_BASE64 | {3'h0, dead_time_setting[5:0]}}
                << `TDTL_SH1;
        end else if (!dead_time_setting[5]) begin
            dt_cyc = {{(DT_W-9){1'b0}}, `TDTL_BASE32 | {4'h0, dead_time_setting[4:0]}}
                << `TDTL_SH3;
        end else begin
            dt_cyc = {{(DT_W-9){1'b0}}, `TDTL_BASE32 | {4'h0, dead_time_setting[4:0]}}
                << `TDTL_SH4;
        end
    end

    // register writes filtered by lock level
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bdt_q <= `TDTL_RST16;
            ctrl2_q <= 2'h0;
            ccen_q <= `TDTL_RST4;
            ccm_q <= `TDTL_RST4;
            lock_done_q <= 1'b0;
        end else if (wr_en) begin
            case (addr)
                `TDTL_OFF_BDT: begin
                    // dead time and brake bits frozen from level one
                    if (!lk1) begin
                        bdt_q[`TDTL_DTS_HI:`TDTL_DTS_LO] <= wdata[7:0];
                        bdt_q[`TDTL_BRAKE_INPUT_ENABLE] <= wdata[`TDTL_BRAKE_INPUT_ENABLE];
                        bdt_q[`TDTL_BRAKE_INPUT_POLARITY] <= wdata[`TDTL_BRAKE_INPUT_POLARITY];
                        bdt_q[`TDTL_AUTOMATIC_OUTPUT_ENABLE] <= wdata[`TDTL_AUTOMATIC_OUTPUT_ENABLE];
                    end
                    // off-state selects frozen from level two
                    if (!lk2) begin
                        bdt_q[`TDTL_IDLE_OFF_STATE_SELECT] <= wdata[`TDTL_IDLE_OFF_STATE_SELECT];
                        bdt_q[`TDTL_RUN_OFF_STATE_SELECT] <= wdata[`TDTL_RUN_OFF_STATE_SELECT];
                    end
                    // lock field written once per reset
                    if (!lock_done_q) begin
                        bdt_q[`TDTL_LOCK_HI:`TDTL_LOCK_LO] <=
                            wdata[`TDTL_LOCK_HI:`TDTL_LOCK_LO];
                        lock_done_q <= 1'b1;
                    end
                    bdt_q[`TDTL_MAIN_OUTPUT_ENABLE] <= wdata[`TDTL_MAIN_OUTPUT_ENABLE];
                end
                `TDTL_OFF_CTRL2: begin
                    if (!lk1) begin
                        ctrl2_q <= wdata[1:0];
                    end
                end
                `TDTL_OFF_CCEN: begin
                    ccen_q[`TDTL_CCEN] <= wdata[`TDTL_CCEN];
                    ccen_q[`TDTL_CCNEN] <= wdata[`TDTL_CCNEN];
                    if (!lk2) begin
                        ccen_q[`TDTL_CCPOL] <= wdata[`TDTL_CCPOL];
                        ccen_q[`TDTL_CCNPOL] <= wdata[`TDTL_CCNPOL];
                    end
                end
                `TDTL_OFF_CCM: begin
                    if (!lk3) begin
                        ccm_q <= wdata[3:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= `TDTL_RST16;
        end else if (rd_en) begin
            case (addr)
                `TDTL_OFF_BDT: rdata <= bdt_q;
                `TDTL_OFF_CTRL2: rdata <= {14'h0000, ctrl2_q};
                `TDTL_OFF_CCEN: rdata <= {12'h000, ccen_q};
                `TDTL_OFF_CCM: rdata <= {12'h000, ccm_q};
                `TDTL_OFF_STAT: rdata <= {13'h0000, startup_q, dt_busy_q,
                    lock_done_q};
                default: rdata <= `TDTL_RST16;
            endcase
        end else begin
            rdata <= `TDTL_RST16;
        end
    end

    assign ch_rise = ch_en && !en_q;
    assign ref_chg = (oc_ref != ref_q);
    assign dt_tick = (dtck_q == DTCK_DIV[DT_W-1:0] - {{(DT_W-1){1'b0}}, 1'b1});
    // end on the tick that completes the last base period, not one later
    assign cnt_done = dt_tick &&
        (cnt_q >= dt_cyc - {{(DT_W-1){1'b0}}, 1'b1});

    // dead-time counter, restarted on every reference edge or enable
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= {DT_W{1'b0}};
            dtck_q <= {DT_W{1'b0}};
            ref_q <= 1'b0;
            en_q <= 1'b0;
            dt_busy_q <= 1'b0;
            startup_q <= 1'b0;
        end else begin
            ref_q <= oc_ref;
            en_q <= ch_en;
            if (ref_chg || ch_rise) begin
                cnt_q <= {DT_W{1'b0}};
                dtck_q <= {DT_W{1'b0}};
                dt_busy_q <= (dt_cyc != {DT_W{1'b0}});
            end else if (dt_busy_q) begin
                dtck_q <= dt_tick ? {DT_W{1'b0}} :
                    dtck_q + {{(DT_W-1){1'b0}}, 1'b1};
                if (dt_tick) begin
                    cnt_q <= cnt_q + {{(DT_W-1){1'b0}}, 1'b1};
                end
                if (cnt_done) begin
                    dt_busy_q <= 1'b0;
                end
            end
            if (ch_rise) begin
                startup_q <= 1'b1;
            end else if (!dt_busy_q || !ch_en) begin
                startup_q <= 1'b0;
            end
        end
    end

    // output shaping for the complementary pair
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_output <= 1'b0;
            channel_output_oe <= 1'b0;
            complementary_output <= 1'b0;
            complementary_output_oe <= 1'b0;
        end else if (!ch_en) begin
            channel_output <= pol;
            complementary_output <= npol;
            channel_output_oe <= 1'b0;
            complementary_output_oe <= 1'b0;
        end else if (!moe) begin
            // idle: inactive during dead time, then idle level
            channel_output_oe <= bdt_q[`TDTL_IDLE_OFF_STATE_SELECT];
            complementary_output_oe <= bdt_q[`TDTL_IDLE_OFF_STATE_SELECT];
            if (dt_busy_q || ch_rise) begin
                channel_output <= pol;
                complementary_output <= npol;
            end else begin
                channel_output <= ctrl2_q[`TDTL_OIS] ^ pol;
                complementary_output <= ctrl2_q[`TDTL_NOIS] ^ npol;
            end
        end else begin
            // run: inactive first, active edges delayed
            channel_output_oe <= bdt_q[`TDTL_RUN_OFF_STATE_SELECT] || !startup_q;
            complementary_output_oe <= bdt_q[`TDTL_RUN_OFF_STATE_SELECT] || !startup_q;
            if (dt_busy_q || ch_rise || ref_chg) begin
                channel_output <= pol;
                complementary_output <= npol;
            end else begin
                channel_output <= ref_q ^ pol;
                complementary_output <= (!ref_q && ccen_q[`TDTL_CCNEN])
                    ^ npol;
            end
        end
    end
endmodule // tdtl_dead_time_lock

// ---- tb/tdtl_dead_time_lock_assertions.sv ----
// assertion checker for the dead-time and write-lock block
`timescale 1ns/10ps
module tdtl_chk (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // register port
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [15:0] rdata,
    // protected settings
    input wire brake_input_enable,
    input wire brake_input_polarity,
    input wire automatic_output_enable,
    input wire [2:0] compare_output_mode,
    input wire compare_preload_enable
);
    reg used_q;
    reg [1:0] lvl_q;
    wire w0 = wr_en && addr == 4'h0;
    wire w3 = wr_en && addr == 4'h3;
    // shadow of the one-shot lock level
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            used_q <= 1'b0;
            lvl_q <= 2'h0;
        end else if (w0 && !used_q) begin
            used_q <= 1'b1;
            lvl_q <= wdata[9:8];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    rdata_idle_a:
    assert property (!$past(rd_en) |-> rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    lock_status_a:
    assert property (rd_en && addr == 4'h4 |=> rdata[0] == $past(used_q))
        else $error("lock written flag wrong");
    brake_free_a:
    assert property (w0 && lvl_q == 2'h0 |=> brake_input_enable == $past(wdata[12]))
        else $error("brake enable not written");
    brake_lock_a:
    assert property (w0 && lvl_q != 2'h0 |=> $stable(brake_input_enable)
        && $stable(brake_input_polarity))
        else $error("brake bits changed while locked");
    auto_lock_a:
    assert property (w0 && lvl_q != 2'h0 |=> $stable(automatic_output_enable))
        else $error("auto output enable changed while locked");
    mode_free_a:
    assert property (w3 && lvl_q != 2'h3 |=> compare_output_mode ==
        $past(wdata[2:0]) && compare_preload_enable == $past(wdata[3]))
        else $error("compare mode not written");
    mode_lock_a:
    assert property (w3 && lvl_q == 2'h3 |=> $stable(compare_output_mode)
        && $stable(compare_preload_enable))
        else $error("compare mode changed while locked");
    brake_hold_a:
    assert property (!w0 |=> $stable(brake_input_enable))
        else $error("brake enable changed without a write");
endmodule // tdtl_chk

bind tdtl_dead_time_lock tdtl_chk i_chk (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .brake_input_enable(brake_input_enable),
    .brake_input_polarity(brake_input_polarity),
    .automatic_output_enable(automatic_output_enable),
    .compare_output_mode(compare_output_mode),
    .compare_preload_enable(compare_preload_enable));

// ---- tb/tdtl_dead_time_lock_tb.sv ----
// self-checking bench for the dead-time and write-lock block
`timescale 1ns/10ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
    n_fail = n_fail + 1; $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end end
module tdtl_dead_time_lock_tb;
    localparam [39:0] DTS_SET = 40'h7f_85_c3_e1_05;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0000;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg oc_ref = 1'b0;
    reg [15:0] d;
    wire [15:0] rdata;
    wire co, coe, no, noe, bke, bkp, aoe, cpe;
    wire [2:0] com;
    wire [3:0] pins = {coe, noe, co, no};
    integer n_fail = 0;
    integer compares = 0;
    integer i, k, n, base, lv;
    tdtl_dead_time_lock i_dut (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .oc_ref(oc_ref), .channel_output(co), .channel_output_oe(coe),
        .complementary_output(no), .complementary_output_oe(noe),
        .brake_input_enable(bke), .brake_input_polarity(bkp),
        .automatic_output_enable(aoe), .compare_output_mode(com),
        .compare_preload_enable(cpe));
    // free-running clock
    initial forever #4 clk = ~clk;
    // expected dead time in base periods
    function integer dt(input [7:0] s);
        begin
            if (!s[7]) dt = s;
            else if (!s[6]) dt = (64 + s[5:0]) * 2;
            else if (!s[5]) dt = (32 + s[4:0]) * 8;
            else dt = (32 + s[4:0]) * 16;
        end
    endfunction
    task complete_run;
        begin
            $display("compares=%0d n_fail=%0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task hang;
        begin
            n_fail = n_fail + 1;
            complete_run;
        end
    endtask
    task do_reset;
        begin
            reset_n <= 1'b0;
            repeat (16) @(posedge clk);
            reset_n <= 1'b1;
        end
    endtask
    task wr(input [3:0] a, input [15:0] v);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= v;
            wr_en <= 1'b1;
            @(posedge clk);
            wr_en <= 1'b0;
        end
    endtask
    task rc(input [3:0] a, input [15:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            @(negedge clk);
            d = rdata;
            `CHK(d, e)
        end
    endtask
    // cycles from a rising reference to the main output going active
    task measure(output integer c);
        begin
            @(posedge clk);
            oc_ref <= 1'b1;
            c = 0;
            @(negedge clk);
            while (co !== 1'b1) begin
                `CHK(co & no, 1'b0)
                c = c + 1;
                if (c > 2000) hang;
                @(negedge clk);
            end
            @(posedge clk);
            oc_ref <= 1'b0;
            i = 0;
            while (no !== 1'b1) begin
                i = i + 1;
                if (i > 2000) hang;
                @(negedge clk);
            end
        end
    endtask
    // main sequence
    initial begin
        do_reset;
        for (k = 0; k < 6; k = k + 1)
            rc(k[3:0], 16'h0000);
        $display("test reset done");
        wr(4'h2, 16'h0005);
        wr(4'h0, 16'h8800);
        measure(base);
        for (k = 0; k < 5; k = k + 1) begin
            wr(4'h0, {8'h88, DTS_SET[k*8 +: 8]});
            measure(n);
            `CHK(n - base, dt(DTS_SET[k*8 +: 8]))
        end
        $display("test dead time done");
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h8840);
        wr(4'h2, 16'h0005);
        repeat (3) @(negedge clk);
        `CHK(pins, 4'b1100)
        $display("test run off-state done");
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h0020);
        wr(4'h1, 16'h0001);
        wr(4'h2, 16'h0005);
        repeat (20) @(negedge clk);
        `CHK(pins[3:2], 2'b00)
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h0420);
        wr(4'h2, 16'h0005);
        repeat (3) @(negedge clk);
        `CHK(pins, 4'b1100)
        repeat (60) @(negedge clk);
        `CHK(pins, 4'b1110)
        $display("test idle off-state done");
        for (lv = 0; lv < 4; lv = lv + 1) begin
            do_reset;
            wr(4'h1, 16'h0003);
            wr(4'h2, 16'h000f);
            wr(4'h3, 16'h000f);
            wr(4'h0, {6'h1f, lv[1:0], 8'h12});
            wr(4'h0, 16'h0300);
            for (k = 1; k < 4; k = k + 1)
                wr(k[3:0], 16'h0000);
            rc(4'h0, {6'h00, lv[1:0], 8'h00} | (lv > 0 ? 16'h7012 : 16'h0000)
                | (lv > 1 ? 16'h0c00 : 16'h0000));
            rc(4'h1, lv > 0 ? 16'h0003 : 16'h0000);
            rc(4'h2, lv > 1 ? 16'h000a : 16'h0000);
            rc(4'h3, lv > 2 ? 16'h000f : 16'h0000);
            `CHK(bke, lv > 0)
            `CHK(com, lv > 2 ? 3'h7 : 3'h0)
        end
        $display("test lock levels done");
        complete_run;
    end
endmodule // tdtl_dead_time_lock_tb
